//--- oag_pkg.sv
// package for operand and branch-target address generation
// Overview of operation
// - eight operand modes; modes an instruction disallows are rejected.
// - register mode returns contents of named register or pair.
// - working mode joins pointer's upper five bits with three field bits.
// - pointer-held mode uses register contents as the operand address.
// - any 8-bit register or 16-bit pair may serve as pointer.
// - pointer-held accesses never reach control locations C0H-FFH.
// - indexed accesses never reach control locations C0H-FFH.
// - short offset to memory is sign-extended, -128 to +127.
// - register-file index: instruction base plus working register offset.
// - memory index: working pair base plus 8 or 16-bit offset.
// - register-file indexed only on plain load; memory loads index memory.
// - absolute mode takes 16-bit address; jump and call load the PC.
// - program and external loads may use absolute source or destination.
// - vector jump reads address pair from lowest 256 program bytes.
// - vector-table jump mode is allowed only for call.
// - PC-offset mode adds signed -128..+127 displacement to the PC.
// - PC already points past the branch before the displacement adds.
// - PC-offset used by bit tests, decrement jump, compare jumps, jr.
// - literal mode passes the instruction's byte or word directly.
package oag_pkg;

   // ----------------------------------------------------------------
   // modes, targets and instruction classes
   // ----------------------------------------------------------------
   typedef enum logic [2:0]
   {
      mode_register = 3'h0,
      mode_pointer_held = 3'h1,
      mode_indexed = 3'h2,
      mode_absolute = 3'h3,
      mode_vector_table = 3'h4,
      mode_pc_offset = 3'h5,
      mode_literal = 3'h6,
      mode_working = 3'h7
   } addr_mode_type;

   typedef enum logic [1:0]
   {
      target_none = 2'h0,
      target_register = 2'h1,
      target_program = 2'h2,
      target_external = 2'h3
   } target_type;

   typedef enum logic [3:0]
   {
      op_load_register = 4'h0,
      op_load_program_memory = 4'h1,
      op_load_external_memory = 4'h2,
      op_jump_absolute = 4'h3,
      op_call = 4'h4,
      op_bit_test_jump_if_false = 4'h5,
      op_bit_test_jump_if_true = 4'h6,
      op_decrement_jump_nonzero = 4'h7,
      op_compare_increment_jump_equal = 4'h8,
      op_compare_increment_jump_unequal = 4'h9,
      op_jump_relative = 4'hA,
      op_generic = 4'hB
   } op_class_type;

   // ----------------------------------------------------------------
   // constants
   // ----------------------------------------------------------------
   localparam logic [7:0] CTRL_BASE = 8'hC0;
   localparam logic [7:0] WORK_PREFIX = 8'hC0;
   localparam int WORK_PREFIX_LSB = 4;
   localparam int RP_SLICE_LSB = 3;
   localparam int PAIR_EVEN_BIT = 0;
   localparam logic [15:0] PC_RESET = 16'h0000;

   // ----------------------------------------------------------------
   // request and answer carriers
   // ----------------------------------------------------------------
   typedef struct packed
   {
      op_class_type op;
      addr_mode_type mode;
      logic is_pair;
      logic short_offset;
      logic [7:0] reg_field;
      logic [7:0] index_reg_field;
      logic [15:0] operand;
   } request_type;

   typedef struct packed
   {
      logic valid;
      logic illegal;
      logic blocked;
      target_type target;
      logic [15:0] address;
      logic [15:0] value;
      logic value_is_data;
      logic pc_load;
      logic [15:0] next_pc;
   } answer_type;

endpackage

//--- operand_address_generation.sv
// operand and branch-target address generation datapath
`timescale 1ns/10ps
module operand_address_generation
   import oag_pkg::*;
(
   // clock and reset
   input wire logic clock_in,
   input wire logic rst_n_in,
   // decoded instruction
   input wire logic req_valid_in,
   input wire request_type req_in,
   input wire logic [15:0] next_instr_pc_in,
   // register pointers
   input wire logic [7:0] rp0_in,
   input wire logic [7:0] rp1_in,
   // register file read ports (combinational)
   output logic [7:0] rf_addr_a_out,
   output logic [7:0] rf_addr_b_out,
   input wire logic [7:0] rf_data_a_in,
   input wire logic [7:0] rf_data_b_in,
   // program memory word read for vector table
   output logic vec_req_out,
   output logic [15:0] vec_addr_out,
   input wire logic vec_ack_in,
   input wire logic [15:0] vec_data_in,
   // result
   output answer_type ans_out
);

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   // working-register name: prefix 1100b selects pointer slice
   function automatic logic [7:0] resolve_reg(input logic [7:0] f,
      input logic [7:0] p0, input logic [7:0] p1);
      logic [7:0] ptr;
      ptr = f[3] ? p1 : p0;
      if (f[7:WORK_PREFIX_LSB] == WORK_PREFIX[7:WORK_PREFIX_LSB])
         resolve_reg = {ptr[7:RP_SLICE_LSB], f[2:0]};
      else
         resolve_reg = f;
   endfunction

   function automatic logic [15:0] sext8(input logic [7:0] v);
      sext8 = {{8{v[7]}}, v};
   endfunction

   function automatic logic in_ctrl(input logic [7:0] a);
      in_ctrl = (a >= CTRL_BASE);
   endfunction

   // ----------------------------------------------------------------
   // register reads
   // ----------------------------------------------------------------
   wire logic [7:0] reg_a = resolve_reg(req_in.reg_field, rp0_in, rp1_in);
   wire logic [7:0] reg_b = resolve_reg(req_in.index_reg_field, rp0_in,
      rp1_in);
   wire logic pair_read = req_in.is_pair ||
      (req_in.mode == mode_indexed && req_in.op != op_load_register);
   // pair is even/odd: high byte at even address
   wire logic [7:0] reg_a_hi = {reg_a[7:1], 1'b0};
   wire logic [7:0] reg_a_lo = {reg_a[7:1], 1'b1};
   assign rf_addr_a_out = pair_read ? reg_a_hi : reg_a;
   assign rf_addr_b_out = pair_read ? reg_a_lo : reg_b;
   wire logic [15:0] pair_val = {rf_data_a_in, rf_data_b_in};
   wire logic [15:0] byte_val = {8'h00, rf_data_a_in};

   // ----------------------------------------------------------------
   // legality
   // ----------------------------------------------------------------
   wire logic is_mem_load = req_in.op == op_load_program_memory ||
      req_in.op == op_load_external_memory;
   wire logic is_rel_op = req_in.op == op_bit_test_jump_if_false ||
      req_in.op == op_bit_test_jump_if_true ||
      req_in.op == op_decrement_jump_nonzero ||
      req_in.op == op_compare_increment_jump_equal ||
      req_in.op == op_compare_increment_jump_unequal ||
      req_in.op == op_jump_relative;
   wire logic is_jump = req_in.op == op_jump_absolute ||
      req_in.op == op_call;
   logic legal;
   always_comb
   begin
      unique case (req_in.mode)
         mode_register, mode_working: legal = !is_rel_op;
         mode_pointer_held: legal = !is_rel_op;
         mode_indexed: legal = req_in.op == op_load_register ||
            is_mem_load;
         mode_absolute: legal = is_jump || is_mem_load;
         mode_vector_table: legal = req_in.op == op_call;
         mode_pc_offset: legal = is_rel_op;
         mode_literal: legal = !is_rel_op && !is_jump;
         default: legal = 1'b0;
      endcase
   end

   // ----------------------------------------------------------------
   // address computation
   // ----------------------------------------------------------------
   wire logic [7:0] rf_index_sum = 8'(req_in.operand[7:0] +
      rf_data_b_in);
   wire logic [15:0] mem_offset = req_in.short_offset ?
      sext8(req_in.operand[7:0]) : req_in.operand;
   wire logic [15:0] mem_index_sum = 16'(pair_val + mem_offset);
   wire logic [15:0] rel_target = 16'(next_instr_pc_in +
      sext8(req_in.operand[7:0]));
   wire logic [15:0] vec_slot = {8'h00, req_in.operand[7:0]};
   wire target_type mem_target = req_in.op == op_load_program_memory ?
      target_program : target_external;

   answer_type comb;
   logic need_vec;
   always_comb
   begin
      comb = '0;
      need_vec = 1'b0;
      comb.illegal = !legal;
      unique case (req_in.mode)
         mode_register, mode_working:
         begin
            comb.target = target_register;
            comb.address = {8'h00, reg_a};
            comb.value = req_in.is_pair ? pair_val : byte_val;
            comb.value_is_data = 1'b1;
         end
         mode_pointer_held:
         begin
            comb.value_is_data = 1'b0;
            if (req_in.is_pair)
            begin
               comb.target = mem_target;
               comb.address = pair_val;
            end
            else
            begin
               comb.target = target_register;
               comb.address = byte_val;
               comb.blocked = in_ctrl(rf_data_a_in);
            end
         end
         mode_indexed:
         begin
            if (req_in.op == op_load_register)
            begin
               comb.target = target_register;
               comb.address = {8'h00, rf_index_sum};
               comb.blocked = in_ctrl(rf_index_sum);
            end
            else
            begin
               comb.target = mem_target;
               comb.address = mem_index_sum;
            end
         end
         mode_absolute:
         begin
            comb.address = req_in.operand;
            if (is_jump)
            begin
               comb.pc_load = 1'b1;
               comb.next_pc = req_in.operand;
            end
            else
               comb.target = mem_target;
         end
         mode_vector_table:
         begin
            comb.target = target_program;
            comb.address = vec_slot;
            need_vec = legal;
         end
         mode_pc_offset:
         begin
            comb.pc_load = 1'b1;
            comb.next_pc = rel_target;
            comb.address = rel_target;
         end
         mode_literal:
         begin
            comb.value = req_in.is_pair ? req_in.operand :
               {8'h00, req_in.operand[7:0]};
            comb.value_is_data = 1'b1;
         end
         default: comb.illegal = 1'b1;
      endcase
      if (!legal)
      begin
         comb.pc_load = 1'b0;
         comb.target = target_none;
      end
   end

   // ----------------------------------------------------------------
   // sequencing: one cycle, or wait for vector fetch
   // ----------------------------------------------------------------
   typedef enum logic [0:0]
   {
      st_idle = 1'b0,
      st_vector = 1'b1
   } state_type;

   state_type state_q;
   state_type state_d;
   answer_type ans_q;
   answer_type ans_d;
   logic [15:0] vec_addr_q;
   logic [15:0] vec_addr_d;

   // holding the slot address keeps the fetch stable while it waits
   always_comb
   begin
      state_d = state_q;
      ans_d = ans_q;
      ans_d.valid = 1'b0;
      vec_addr_d = vec_addr_q;
      unique case (state_q)
         st_idle:
         begin
            if (req_valid_in && need_vec)
            begin
               state_d = st_vector;
               vec_addr_d = vec_slot;
               ans_d = comb;
               ans_d.valid = 1'b0;
            end
            else if (req_valid_in)
            begin
               ans_d = comb;
               ans_d.valid = 1'b1;
            end
         end
         st_vector:
         begin
            if (vec_ack_in)
            begin
               state_d = st_idle;
               ans_d.valid = 1'b1;
               ans_d.pc_load = 1'b1;
               ans_d.next_pc = vec_data_in;
            end
         end
      endcase
   end

   assign vec_req_out = state_q == st_vector;
   assign vec_addr_out = vec_addr_q;
   assign ans_out = ans_q;

   always_ff @(posedge clock_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         state_q <= st_idle;
         ans_q <= '0;
         vec_addr_q <= PC_RESET;
      end
      else
      begin
         state_q <= state_d;
         ans_q <= ans_d;
         vec_addr_q <= vec_addr_d;
      end
   end

endmodule // operand_address_generation

//--- oag_properties.sv
// assertion checker for the operand address generator
`timescale 1ns/10ps
module oag_checker
   import oag_pkg::*;
(
   // watched ports
   input wire logic clock_in,
   input wire logic rst_n_in,
   input wire logic req_valid_in,
   input wire request_type req_in,
   input wire logic [15:0] next_instr_pc_in,
   input wire logic vec_req_out,
   input wire logic [15:0] vec_addr_out,
   input wire logic vec_ack_in,
   input wire logic [15:0] vec_data_in,
   input wire answer_type ans_out
);
   default clocking cb @(posedge clock_in);
   endclocking
   default disable iff (!rst_n_in);
   // requests only count while no table fetch is pending
   wire logic take = req_valid_in && !vec_req_out;
   wire logic vec = req_in.mode == mode_vector_table;
   wire logic fetch = vec && req_in.op == op_call;
   wire logic jmp = req_in.op inside {op_jump_absolute, op_call};
   wire logic rel = req_in.op inside
      {[op_bit_test_jump_if_false:op_jump_relative]};
   wire logic [15:0] rel_pc = next_instr_pc_in
      + {{8{req_in.operand[7]}}, req_in.operand[7:0]};
   wire logic [15:0] lit = req_in.is_pair ? req_in.operand
      : {8'h00, req_in.operand[7:0]};
   wire logic ld = req_in.op inside {op_load_register,
      op_load_program_memory, op_load_external_memory};
   property p_fetch;
      take && fetch |=> vec_req_out && !ans_out.valid
         && vec_addr_out == {8'h00, $past(req_in.operand[7:0])};
   endproperty
   a_fetch: assert property (p_fetch) else $error("slot");
   property p_fetch_end;
      vec_req_out && vec_ack_in |=> ans_out.valid && ans_out.pc_load
         && !vec_req_out && ans_out.next_pc == $past(vec_data_in);
   endproperty
   a_fetch_end: assert property (p_fetch_end) else $error("vector");
   property p_call_only;
      take && vec && !fetch |=> ans_out.illegal && !vec_req_out;
   endproperty
   a_call_only: assert property (p_call_only) else $error("call");
   property p_rel;
      take && req_in.mode == mode_pc_offset && rel |=> !ans_out.illegal
         && ans_out.next_pc == $past(rel_pc);
   endproperty
   a_rel: assert property (p_rel) else $error("rel");
   property p_abs;
      take && req_in.mode == mode_absolute && jmp |=> ans_out.pc_load
         && ans_out.next_pc == $past(req_in.operand);
   endproperty
   a_abs: assert property (p_abs) else $error("abs");
   property p_refused;
      ans_out.valid && ans_out.illegal |->
         ans_out.target == target_none && !ans_out.pc_load;
   endproperty
   a_refused: assert property (p_refused) else $error("refuse");
   property p_index_ops;
      take && req_in.mode == mode_indexed && !ld |=> ans_out.illegal;
   endproperty
   a_index_ops: assert property (p_index_ops) else $error("index");
   property p_literal;
      take && req_in.mode == mode_literal && req_in.op == op_generic
         |=> ans_out.value_is_data && ans_out.value == $past(lit);
   endproperty
   a_literal: assert property (p_literal) else $error("literal");
   c_fetch: cover property (take && fetch);
   c_ack: cover property (vec_req_out && vec_ack_in);
   c_blocked: cover property (ans_out.valid && ans_out.blocked);
endmodule // oag_checker

bind operand_address_generation oag_checker u_oag_checker (
   .clock_in(clock_in), .rst_n_in(rst_n_in), .req_valid_in(req_valid_in),
   .req_in(req_in), .next_instr_pc_in(next_instr_pc_in),
   .vec_req_out(vec_req_out), .vec_addr_out(vec_addr_out),
   .vec_ack_in(vec_ack_in), .vec_data_in(vec_data_in), .ans_out(ans_out));

//--- oag_memory_model.sv
// register file and vector table model beside the address generator
`timescale 1ns/10ps
module oag_memory_model
(
   // register file reads
   input wire logic clock_in,
   input wire logic slow_in,
   input wire logic [7:0] rf_addr_a_in,
   input wire logic [7:0] rf_addr_b_in,
   output logic [7:0] rf_data_a_out,
   output logic [7:0] rf_data_b_out,
   // vector table word reads
   input wire logic vec_req_in,
   input wire logic [15:0] vec_addr_in,
   output logic vec_ack_out,
   output logic [15:0] vec_data_out
);
   int wait_q;
   logic [15:0] word;
   // scrambled contents keep every expected value predictable
   assign rf_data_a_out = rf_addr_a_in ^ 8'h5A;
   assign rf_data_b_out = rf_addr_b_in ^ 8'h5A;
   assign word = {vec_addr_in[7:0] ^ 8'h3C, 8'h81};
   // data inverted outside the ack cycle so stale data never matches
   assign vec_data_out = vec_ack_out ? word : ~word;
   initial
   begin
      wait_q = 0;
      vec_ack_out = 1'b0;
   end
   always @(negedge clock_in)
   begin
      wait_q <= (vec_req_in && !vec_ack_out) ? wait_q + 1 : 0;
      vec_ack_out <= vec_req_in && !vec_ack_out
         && wait_q == (slow_in ? 5 : 0);
   end
endmodule // oag_memory_model

//--- operand_address_generation_test.sv
// self-checking bench for the operand address generator
`timescale 1ns/10ps
module operand_address_generation_test;
   import oag_pkg::*;
   logic clock_in, rst_n_in, req_valid_in, vec_ack_in, vec_req_out, slow;
   logic [7:0] rp0_in, rp1_in, rf_addr_a_out, rf_addr_b_out;
   logic [7:0] rf_data_a_in, rf_data_b_in;
   logic [15:0] next_instr_pc_in, vec_addr_out, vec_data_in;
   request_type req_in;
   answer_type ans_out;
   int mismatches = 0;
   int n_tests = 0;
   operand_address_generation u_operand_address_generation (
      .clock_in(clock_in), .rst_n_in(rst_n_in), .req_valid_in(req_valid_in),
      .req_in(req_in), .next_instr_pc_in(next_instr_pc_in), .rp0_in(rp0_in),
      .rp1_in(rp1_in), .rf_addr_a_out(rf_addr_a_out),
      .rf_addr_b_out(rf_addr_b_out), .rf_data_a_in(rf_data_a_in),
      .rf_data_b_in(rf_data_b_in), .vec_req_out(vec_req_out),
      .vec_addr_out(vec_addr_out), .vec_ack_in(vec_ack_in),
      .vec_data_in(vec_data_in), .ans_out(ans_out));
   oag_memory_model u_oag_memory_model (
      .clock_in(clock_in), .slow_in(slow), .rf_addr_a_in(rf_addr_a_out),
      .rf_addr_b_in(rf_addr_b_out), .rf_data_a_out(rf_data_a_in),
      .rf_data_b_out(rf_data_b_in), .vec_req_in(vec_req_out),
      .vec_addr_in(vec_addr_out), .vec_ack_out(vec_ack_in),
      .vec_data_out(vec_data_in));
   function automatic request_type rq(op_class_type op, addr_mode_type m,
      logic [15:0] opd, logic [7:0] rf = 8'h00, logic [7:0] ix = 8'h00,
      logic pr = 1'b0, logic sh = 1'b0);
      rq = '{op, m, pr, sh, rf, ix, opd};
   endfunction
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("wrong value at %0t: %h, expected %h", $time, seen, exp);
      end
   endtask
   // request stays up so the caller can chain the next one
   task automatic send(input request_type r);
      req_in = r;
      req_valid_in = 1'b1;
      @(negedge clock_in);
   endtask
   task automatic idle;
      req_valid_in = 1'b0;
      @(negedge clock_in);
   endtask
   task automatic t_register;
      rp0_in = 8'h70;
      rp1_in = 8'hA8;
      send(rq(op_generic, mode_working, 16'h0000, 8'hC6));
      chk(rf_addr_a_out, 8'h76);
      send(rq(op_generic, mode_working, 16'h0000, 8'hCB));
      chk({rf_addr_a_out, ans_out.value[7:0]}, 16'hABF1);
      send(rq(op_generic, mode_register, 16'h0000, 8'h20, 8'h00, 1'b1));
      chk(ans_out.value, 16'h7A7B);
      chk(rf_addr_b_out, 8'h21);
      idle;
      $display("register test done");
   endtask
   task automatic t_pointer;
      send(rq(op_load_register, mode_pointer_held, 16'h0000, 8'h10));
      chk({ans_out.blocked, ans_out.address}, {1'b0, 16'h004A});
      send(rq(op_load_register, mode_pointer_held, 16'h0000, 8'h9A));
      chk(ans_out.blocked, 1'b1);
      send(rq(op_load_program_memory, mode_pointer_held, 16'h0000, 8'h20,
         8'h00, 1'b1));
      chk({ans_out.target, ans_out.address}, {target_program, 16'h7A7B});
      idle;
      $display("pointer test done");
   endtask
   task automatic t_indexed;
      send(rq(op_load_register, mode_indexed, 16'h0050, 8'h00, 8'h30));
      chk({ans_out.blocked, ans_out.address}, {1'b0, 16'h00BA});
      send(rq(op_load_register, mode_indexed, 16'h00F0, 8'h00, 8'h30));
      chk({ans_out.blocked, ans_out.address}, {1'b0, 16'h005A});
      send(rq(op_load_register, mode_indexed, 16'h0056, 8'h00, 8'h30));
      chk(ans_out.blocked, 1'b1);
      send(rq(op_load_external_memory, mode_indexed, 16'h0080, 8'h20,
         8'h00, 1'b1, 1'b1));
      chk({ans_out.target, ans_out.address}, {target_external, 16'h79FB});
      send(rq(op_load_program_memory, mode_indexed, 16'h1234, 8'h20,
         8'h00, 1'b1));
      chk({ans_out.target, ans_out.address}, {target_program, 16'h8CAF});
      send(rq(op_jump_relative, mode_indexed, 16'h0005));
      chk(ans_out.illegal, 1'b1);
      send(rq(op_load_external_memory, mode_absolute, 16'hBEEF));
      chk({ans_out.target, ans_out.address}, {target_external, 16'hBEEF});
      send(rq(op_call, mode_absolute, 16'h4321));
      chk({ans_out.pc_load, ans_out.next_pc}, {1'b1, 16'h4321});
      send(rq(op_generic, mode_literal, 16'hA55A));
      chk({ans_out.value_is_data, ans_out.value}, {1'b1, 16'h005A});
      idle;
      $display("indexed and absolute test done");
   endtask
   task automatic t_relative;
      logic [7:0] d[3] = '{8'h80, 8'h7F, 8'hFE};
      // targets wrap inside 16 bits: 0102 - 80, 0102 + 7F, 0102 - 2
      logic [15:0] e[3] = '{16'h0082, 16'h0181, 16'h0100};
      next_instr_pc_in = 16'h0102;
      for (int i = 0; i < 6; i++)
      begin
         send(rq(op_class_type'(4'h5 + 4'(i)), mode_pc_offset,
            {8'h00, d[i % 3]}));
         chk(ans_out.next_pc, e[i % 3]);
      end
      send(rq(op_jump_absolute, mode_vector_table, 16'h0020));
      chk({ans_out.illegal, vec_req_out}, 2'b10);
      idle;
      $display("relative test done");
   endtask
   task automatic t_vector(input logic sl, input logic [7:0] slot);
      int n = 0;
      slow = sl;
      send(rq(op_call, mode_vector_table, {8'h00, slot}));
      chk(vec_addr_out, {8'h00, slot});
      send(rq(op_jump_absolute, mode_absolute, 16'h1111));
      req_valid_in = 1'b0;
      while (ans_out.valid !== 1'b1 && n < 20)
      begin
         @(negedge clock_in);
         n++;
      end
      chk(ans_out.next_pc, {slot ^ 8'h3C, 8'h81});
      @(negedge clock_in);
      chk(ans_out.valid, 1'b0);
      $display("vector test done");
   endtask
   task automatic close_out;
      $display("%0d compares, %0d mismatches", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   initial
   begin
      clock_in = 1'b0;
      forever #2.5 clock_in = ~clock_in;
   end
   initial
   begin
      rst_n_in = 1'b0;
      req_valid_in = 1'b0;
      req_in = '0;
      next_instr_pc_in = 16'h0000;
      rp0_in = 8'h00;
      rp1_in = 8'h00;
      slow = 1'b0;
      repeat (5) @(negedge clock_in);
      chk({ans_out.valid, vec_req_out}, 2'b00);
      rst_n_in = 1'b1;
      t_register;
      t_pointer;
      t_indexed;
      t_relative;
      t_vector(1'b1, 8'h20);
      t_vector(1'b0, 8'hFF);
      close_out;
   end
   // far beyond the few dozen cycles the tests need
   initial
   begin
      #2000;
      mismatches++;
      close_out;
   end
endmodule // operand_address_generation_test
